// ---- fdh_frame_descriptor_handler.sv ----
// Functional notes
// (R1) Fixed offsets: conf, status, link, length
// (R2) Response pointer 16/18, frame control 1B
// (R3) Short addresses: destination 1C, source 1E
// (R4) Long addresses: destination 1C-21, source 22-27
// (R5) Transmit confirmation word flag layout
// (R6) Done flag set when frame finished
// (R7) Queue-empty follows next link valid
// (R8) Too long: send shorter, abort, flag
// (R9) No-answer flag with negative or retry
// (R10) Attempt count, or retries at limit
// (R11) Host zeroes confirmation word first
// (R12) Receive bit 15 marks next link valid
// (R13) Host zeroes receive status first
// (R14) Receive error bits, accept per mask
// (R15) CRC frame whole, CRC per mode
// (R16) End delimiter error: bytes heard length
// (R17) Overrun or noise: bytes copied length
// (R18) Over 8K: copied whole, flag set
// (R19) No buffers: true length, flag set
// (R20) Last pool descriptor sets pool empty
// (R21) Pool low warning sets pool low
// (R22) Write first buffer pointer on receive
// (R23) Write answer address into response pointer
// (R24) Descriptors sit at even addresses
`timescale 1ns/1ps
`default_nettype none

module fdh_frame_descriptor_handler (
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Shared memory master, 16-bit words
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic [1:0] mem_be,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack,
   // Transmit completion
   input wire logic tx_cmp_valid,
   output logic tx_cmp_ready,
   input wire logic [31:0] tx_desc,
   input wire logic tx_negative,
   input wire logic tx_starvation,
   input wire logic tx_no_answer,
   input wire logic tx_answer_on_retry,
   input wire logic tx_unexpected,
   input wire logic [7:0] tx_attempts,
   input wire logic [7:0] tx_retries,
   input wire logic tx_retry_limit,
   input wire logic [15:0] tx_data_len,
   input wire logic [15:0] tx_first_buf_len,
   output logic tx_len_valid,
   output logic [15:0] tx_send_len,
   output logic tx_abort,
   // Receive completion
   input wire logic rx_cmp_valid,
   output logic rx_cmp_ready,
   input wire logic [31:0] rx_desc,
   input wire logic rx_crc_err,
   input wire logic rx_end_delimiter_error_flag_err,
   input wire logic rx_fifo_ovf,
   input wire logic rx_noise,
   input wire logic rx_no_buf,
   input wire logic [15:0] rx_bytes_heard,
   input wire logic [15:0] rx_bytes_copied,
   input wire logic [31:0] rx_first_bd,
   input wire logic [7:0] rx_frame_ctrl,
   input wire logic [47:0] rx_dst_addr,
   input wire logic [47:0] rx_src_addr,
   input wire logic rx_next_valid,
   output logic rx_verdict_valid,
   output logic rx_accept,
   // Request-with-response answer link
   input wire logic ir_valid,
   output logic ir_ready,
   input wire logic [31:0] ir_req_desc,
   input wire logic [31:0] ir_ans_desc
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   fdh_pkg::fdh_state_t state_q;
   fdh_pkg::fdh_job_t job_q;
   logic [3:0] step_q;
   logic [31:0] base_q;
   logic [31:0] ptr_q;
   logic [15:0] conf_q;
   logic [15:0] len_q;
   logic [5:0] stat_q;
   logic [7:0] fc_q;
   logic [47:0] dst_q;
   logic [47:0] src_q;
   logic nrv_q;
   logic npv_q;
   logic ftl_q;
   logic [15:0] first_buf_q;
   logic [15:0] data_len_q;
   logic address_length_select_q;
   logic store_crc_q;
   logic [5:0] mask_q;
   logic [1:0] evt_q;
   logic bus_ack_q;
   logic [31:0] rdata_q;
   logic tx_len_valid_q;
   logic [15:0] tx_send_len_q;
   logic tx_abort_q;
   logic verdict_q;
   logic accept_q;
   logic [7:0] step_off;
   logic [15:0] step_data;
   logic [1:0] step_be;
   logic step_we;
   logic step_last;
   logic [15:0] addr_word;

   // ----------------------------------------
   // Decode of requests and accesses
   // ----------------------------------------
   wire idle = (state_q == fdh_pkg::FDH_IDLE);
   wire tx_take = tx_cmp_valid & tx_cmp_ready;
   wire rx_take = rx_cmp_valid & rx_cmp_ready;
   wire ir_take = ir_valid & ir_ready;
   wire acc_done = mem_req & mem_ack;
   wire rx_over = rx_bytes_heard > fdh_pkg::OVER_LEN_LIMIT;
   wire [5:0] rx_err = {rx_crc_err, rx_end_delimiter_error_flag_err, rx_fifo_ovf, rx_noise, rx_over, rx_no_buf}; // R14
   wire rx_ok = ~|(rx_err & ~mask_q); // R14
   wire [3:0] addr_idx = step_q - fdh_pkg::RX_ADDR_STEP;
   wire [3:0] addr_words = address_length_select_q ? fdh_pkg::ADDR_WORDS_LONG : fdh_pkg::ADDR_WORDS_SHORT;
   wire [15:0] crc_add = store_crc_q ? fdh_pkg::CRC_BYTES : 16'h0000;
   wire [7:0] tx_count = tx_retry_limit ? tx_retries : tx_attempts; // R10
   wire tx_neg = tx_negative | tx_no_answer; // R9
   wire tx_nr = tx_no_answer | tx_answer_on_retry; // R9
   wire len_rd = acc_done & (job_q == fdh_pkg::FDH_JOB_TX) & (step_q == 4'h1);
   wire ctrl_rd = acc_done & (job_q == fdh_pkg::FDH_JOB_RX) & (step_q == 4'h0);

   // Grants: transmit first, then receive, then answer links
   assign tx_cmp_ready = idle;
   assign rx_cmp_ready = idle & ~tx_cmp_valid;
   assign ir_ready = idle & ~tx_cmp_valid & ~rx_cmp_valid;

   // Received length by error kind
   logic [15:0] rx_len;
   always_comb begin
      if (rx_fifo_ovf | rx_noise) begin
         rx_len = rx_bytes_copied; // R17
      end else if (rx_over) begin
         rx_len = rx_bytes_copied; // R18
      end else if (rx_end_delimiter_error_flag_err | rx_no_buf) begin
         rx_len = rx_bytes_heard; // R16 R19
      end else begin
         rx_len = 16'(rx_bytes_heard + crc_add); // R15
      end
   end

   // Address word selection by address length
   always_comb begin
      if (address_length_select_q) begin
         case (addr_idx) // R4
            4'h0: addr_word = dst_q[15:0];
            4'h1: addr_word = dst_q[31:16];
            4'h2: addr_word = dst_q[47:32];
            4'h3: addr_word = src_q[15:0];
            4'h4: addr_word = src_q[31:16];
            default: addr_word = src_q[47:32];
         endcase
      end else begin
         addr_word = (addr_idx == 4'h0) ? dst_q[15:0] : src_q[15:0]; // R3
      end
   end

   // ----------------------------------------
   // Access step table
   // ----------------------------------------
   always_comb begin
      step_off = fdh_pkg::FD_CONF;
      step_data = 16'h0000;
      step_be = 2'b11;
      step_we = 1'b1;
      step_last = 1'b0;
      case (job_q)
         fdh_pkg::FDH_JOB_TX: begin
            if (step_q == 4'h0) begin
               step_off = fdh_pkg::FD_NEXT_CTRL;
               step_we = 1'b0;
            end else if (step_q == 4'h1) begin
               step_off = fdh_pkg::FD_LEN;
               step_we = 1'b0;
            end else begin
               step_last = 1'b1;
               step_data = conf_q;
               step_data[fdh_pkg::CONF_EMP_BIT] = ~npv_q; // R7
               step_data[fdh_pkg::CONF_FTL_BIT] = ftl_q; // R8
            end
         end
         fdh_pkg::FDH_JOB_RX: begin
            if (step_q == 4'h0) begin
               step_off = fdh_pkg::FD_NEXT_CTRL;
               step_we = 1'b0;
            end else if (step_q == 4'h1) begin
               step_off = fdh_pkg::FD_RXSTAT;
               step_data = {stat_q, 10'h000}; // R14
            end else if (step_q == 4'h2) begin
               step_off = fdh_pkg::FD_LEN; // R1
               step_data = len_q;
            end else if (step_q == 4'h3) begin
               step_off = fdh_pkg::FD_BD_HI; // R22
               step_data = ptr_q[31:16];
            end else if (step_q == 4'h4) begin
               step_off = fdh_pkg::FD_BD_LO; // R22
               step_data = ptr_q[15:0];
            end else if (step_q == 4'h5) begin
               step_off = fdh_pkg::FD_FC_WORD; // R2
               step_data = {fc_q, 8'h00};
               step_be = 2'b10;
            end else if (addr_idx < addr_words) begin
               step_off = 8'(fdh_pkg::FD_ADDR + {3'h0, addr_idx, 1'b0}); // R3 R4
               step_data = addr_word;
            end else begin
               step_last = 1'b1;
               step_data[fdh_pkg::NRV_BIT] = nrv_q; // R12
            end
         end
         default: begin
            if (step_q == 4'h0) begin
               step_off = fdh_pkg::FD_IR_HI; // R23
               step_data = ptr_q[31:16];
            end else begin
               step_off = fdh_pkg::FD_IR_LO; // R23
               step_data = ptr_q[15:0];
               step_last = 1'b1;
            end
         end
      endcase
   end

   // Memory master drive
   assign mem_req = (state_q == fdh_pkg::FDH_ACCESS);
   assign mem_we = mem_req & step_we;
   assign mem_addr = base_q + {24'h00_0000, step_off}; // R1 R24
   assign mem_wdata = step_data;
   assign mem_be = step_be;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= fdh_pkg::FDH_IDLE;
         job_q <= fdh_pkg::FDH_JOB_TX;
         step_q <= 4'h0;
      end else begin
         case (state_q)
            fdh_pkg::FDH_IDLE: begin
               step_q <= 4'h0;
               if (tx_take) begin
                  state_q <= fdh_pkg::FDH_ACCESS;
                  job_q <= fdh_pkg::FDH_JOB_TX;
               end else if (rx_take && rx_ok) begin
                  state_q <= fdh_pkg::FDH_ACCESS;
                  job_q <= fdh_pkg::FDH_JOB_RX;
               end else if (ir_take) begin
                  state_q <= fdh_pkg::FDH_ACCESS;
                  job_q <= fdh_pkg::FDH_JOB_IR;
               end
            end
            fdh_pkg::FDH_ACCESS: begin
               if (acc_done) begin
                  step_q <= 4'(step_q + 4'h1);
                  if (step_last) begin
                     state_q <= fdh_pkg::FDH_IDLE;
                  end
               end
            end
            default: state_q <= fdh_pkg::FDH_IDLE;
         endcase
      end
   end

   // Job capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q <= 32'h0000_0000;
         ptr_q <= 32'h0000_0000;
         conf_q <= 16'h0000;
         data_len_q <= 16'h0000;
         first_buf_q <= 16'h0000;
      end else if (tx_take) begin
         base_q <= tx_desc;
         conf_q <= {1'b1, tx_neg, 2'b00, 1'b0, tx_starvation, tx_nr, tx_unexpected, tx_count}; // R5 R6
         data_len_q <= tx_data_len;
         first_buf_q <= tx_first_buf_len;
      end else if (rx_take) begin
         base_q <= rx_desc;
         ptr_q <= rx_first_bd; // R22
      end else if (ir_take) begin
         base_q <= ir_req_desc;
         ptr_q <= ir_ans_desc; // R23
      end
   end

   // Receive fields capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 6'h00;
         len_q <= 16'h0000;
         fc_q <= 8'h00;
         dst_q <= 48'h0000_0000_0000;
         src_q <= 48'h0000_0000_0000;
         nrv_q <= 1'b0;
      end else if (rx_take) begin
         stat_q <= rx_err; // R14 R18 R19
         len_q <= rx_len;
         fc_q <= rx_frame_ctrl;
         dst_q <= rx_dst_addr;
         src_q <= rx_src_addr;
         nrv_q <= rx_next_valid; // R12
      end
   end

   // Transmit length check and link state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         npv_q <= 1'b0;
         ftl_q <= 1'b0;
         tx_len_valid_q <= 1'b0;
         tx_send_len_q <= 16'h0000;
         tx_abort_q <= 1'b0;
      end else begin
         tx_len_valid_q <= len_rd;
         if (acc_done && !step_we && step_q == 4'h0) begin
            npv_q <= mem_rdata[fdh_pkg::NPV_BIT];
         end
         if (len_rd) begin
            ftl_q <= data_len_q > mem_rdata; // R8
            tx_abort_q <= data_len_q > mem_rdata; // R8
            tx_send_len_q <= (first_buf_q < mem_rdata) ? first_buf_q : mem_rdata; // R8
         end
      end
   end

   // Receive verdict pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         verdict_q <= 1'b0;
         accept_q <= 1'b0;
      end else begin
         verdict_q <= rx_take;
         accept_q <= rx_take & rx_ok; // R14
      end
   end

   assign tx_len_valid = tx_len_valid_q;
   assign tx_send_len = tx_send_len_q;
   assign tx_abort = tx_abort_q;
   assign rx_verdict_valid = verdict_q;
   assign rx_accept = accept_q;

   // ----------------------------------------
   // Avalon-MM register slave
   // ----------------------------------------
   wire bus_req = avs_read | avs_write;
   wire wr_fire = avs_write & bus_ack_q;
   wire [1:0] reg_sel = avs_address[3:2];
   wire evt_clr_empty = wr_fire & (reg_sel == fdh_pkg::REG_EVENT) & avs_byteenable[0]
                        & avs_writedata[fdh_pkg::EVT_EMPTY_BIT];
   wire evt_clr_low = wr_fire & (reg_sel == fdh_pkg::REG_EVENT) & avs_byteenable[0]
                      & avs_writedata[fdh_pkg::EVT_LOW_BIT];
   wire evt_set_empty = ctrl_rd & ~mem_rdata[fdh_pkg::NPV_BIT];
   wire evt_set_low = ctrl_rd & mem_rdata[fdh_pkg::WFD_BIT];
   assign avs_waitrequest = bus_req & ~bus_ack_q;
   assign avs_readdata = rdata_q;

   // Read mux
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_sel)
         fdh_pkg::REG_CTRL: rd_mux = {30'h0000_0000, store_crc_q, address_length_select_q};
         fdh_pkg::REG_MASK: rd_mux = {16'h0000, mask_q, 10'h000};
         fdh_pkg::REG_EVENT: rd_mux = {30'h0000_0000, evt_q};
         default: rd_mux = {30'h0000_0000, job_q == fdh_pkg::FDH_JOB_RX, ~idle};
      endcase
   end

   // Bus answer after one wait cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         bus_ack_q <= bus_req & ~bus_ack_q;
         if (avs_read && !bus_ack_q) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Software registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         address_length_select_q <= fdh_pkg::CTRL_RST[0];
         store_crc_q <= fdh_pkg::CTRL_RST[1];
         mask_q <= fdh_pkg::MASK_RST;
      end else if (wr_fire) begin
         if (reg_sel == fdh_pkg::REG_CTRL && avs_byteenable[0]) begin
            address_length_select_q <= avs_writedata[0];
            store_crc_q <= avs_writedata[1];
         end
         if (reg_sel == fdh_pkg::REG_MASK && avs_byteenable[1]) begin
            mask_q <= avs_writedata[15:10];
         end
      end
   end

   // Pool events; a set beats a clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_q <= 2'b00;
      end else begin
         evt_q[fdh_pkg::EVT_EMPTY_BIT] <= evt_set_empty | (evt_q[0] & ~evt_clr_empty); // R20
         evt_q[fdh_pkg::EVT_LOW_BIT] <= evt_set_low | (evt_q[1] & ~evt_clr_low); // R21
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   wire tx_conf_wr = mem_req & mem_we & (job_q == fdh_pkg::FDH_JOB_TX);
   wire rx_last_wr = mem_req & step_last & (job_q == fdh_pkg::FDH_JOB_RX);

   sequence rx_ctrl_seen_s;
      ctrl_rd ##1 1'b1;
   endsequence

   sequence tx_check_s;
      len_rd ##1 tx_len_valid;
   endsequence

   done_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
      tx_conf_wr |-> mem_wdata[15] && mem_addr == base_q)
      else $error("done flag missing in confirmation");
   queue_empty_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
      tx_conf_wr |-> mem_wdata[13] == ~npv_q)
      else $error("queue empty flag wrong");
   too_long_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
      tx_check_s |-> tx_abort == ftl_q && tx_send_len <= first_buf_q)
      else $error("too long handling wrong");
   attempts_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
      tx_take |=> conf_q[7:0] == ($past(tx_retry_limit) ? $past(tx_retries)
                                  : $past(tx_attempts)))
      else $error("attempt count wrong");
   no_answer_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
      tx_take && tx_no_answer |=> conf_q[14] && conf_q[9])
      else $error("no answer flags wrong");
   rx_link_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
      rx_last_wr |-> mem_addr == base_q && mem_wdata[15] == nrv_q)
      else $error("receive link bit wrong");
   pool_empty_a: assert property (@(posedge clk) disable iff (!rst_n) // R20
      rx_ctrl_seen_s and (ctrl_rd && !mem_rdata[15]) |=> evt_q[0])
      else $error("pool empty not set");
   rx_reject_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
      rx_take && !rx_ok |=> idle && !rx_accept ##1 1'b1)
      else $error("masked error frame accepted");
   bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");

endmodule

`default_nettype wire

// ---- fdh_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Shared descriptor memory on the host side
// ----------------------------------------
module fdh_mem_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] lat,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] mem_be,
   output logic [15:0] mem_rdata,
   output logic mem_ack
);
   logic [15:0] mem [0:255];
   logic [15:0] rd_q;
   logic [1:0] cnt_q;
   wire logic [7:0] idx = mem_addr[8:1];
   // Idle data lines show the inverse of the last word
   assign mem_rdata = mem_ack ? rd_q : ~rd_q;
   // One ack pulse per access after lat wait cycles
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         cnt_q <= 2'h0;
         rd_q <= 16'h0000;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
      end else if (mem_req && cnt_q >= lat) begin
         mem_ack <= 1'b1;
         cnt_q <= 2'h0;
         rd_q <= mem[idx];
         if (mem_we && mem_be[0]) mem[idx][7:0] <= mem_wdata[7:0];
         if (mem_we && mem_be[1]) mem[idx][15:8] <= mem_wdata[15:8];
      end else if (mem_req) begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule

`default_nettype wire

// ---- fdh_pkg.sv ----
package fdh_pkg;

   // ----------------------------------------
   // Frame descriptor byte displacements
   // ----------------------------------------
   localparam logic [7:0] FD_CONF = 8'h00;
   localparam logic [7:0] FD_RXSTAT = 8'h02;
   localparam logic [7:0] FD_NEXT_CTRL = 8'h04;
   localparam logic [7:0] FD_NEXT_HI = 8'h06;
   localparam logic [7:0] FD_NEXT_LO = 8'h08;
   localparam logic [7:0] FD_BD_HI = 8'h0C;
   localparam logic [7:0] FD_BD_LO = 8'h0E;
   localparam logic [7:0] FD_LEN = 8'h10;
   localparam logic [7:0] FD_IR_HI = 8'h16;
   localparam logic [7:0] FD_IR_LO = 8'h18;
   localparam logic [7:0] FD_FC_WORD = 8'h1A;
   localparam logic [7:0] FD_ADDR = 8'h1C;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CONF_DONE_BIT = 15;
   localparam int CONF_NEG_BIT = 14;
   localparam int CONF_EMP_BIT = 13;
   localparam int CONF_FTL_BIT = 12;
   localparam int CONF_UR_BIT = 10;
   localparam int CONF_NR_BIT = 9;
   localparam int CONF_UF_BIT = 8;
   localparam int NPV_BIT = 15;
   localparam int WFD_BIT = 14;
   localparam int NRV_BIT = 15;
   localparam int RXST_LSB = 10;

   // ----------------------------------------
   // Limits and counts
   // ----------------------------------------
   localparam logic [15:0] OVER_LEN_LIMIT = 16'h2000;
   localparam logic [15:0] CRC_BYTES = 16'h0004;
   localparam logic [3:0] RX_ADDR_STEP = 4'h6;
   localparam logic [3:0] ADDR_WORDS_SHORT = 4'h2;
   localparam logic [3:0] ADDR_WORDS_LONG = 4'h6;

   // ----------------------------------------
   // Register map and reset values
   // ----------------------------------------
   localparam logic [1:0] REG_CTRL = 2'h0;
   localparam logic [1:0] REG_MASK = 2'h1;
   localparam logic [1:0] REG_EVENT = 2'h2;
   localparam logic [1:0] REG_STATE = 2'h3;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [5:0] MASK_RST = 6'h00;
   localparam int EVT_EMPTY_BIT = 0;
   localparam int EVT_LOW_BIT = 1;

   typedef enum {FDH_IDLE, FDH_ACCESS} fdh_state_t;
   typedef enum {FDH_JOB_TX, FDH_JOB_RX, FDH_JOB_IR} fdh_job_t;

endpackage

// ---- frame_descriptor_handler_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module frame_descriptor_handler_tb;
   logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = '0, avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = '0, avs_readdata, mem_addr;
   logic avs_waitrequest, mem_req, mem_we, mem_ack, tx_cmp_ready, tx_len_valid, tx_abort;
   logic [15:0] mem_wdata, mem_rdata, tx_send_len;
   logic [1:0] mem_be, lat = '0;
   logic tx_cmp_valid = 0, tx_negative = 0, tx_starvation = 0, tx_no_answer = 0;
   logic tx_answer_on_retry = 0, tx_unexpected = 0, tx_retry_limit = 0;
   logic [31:0] tx_desc = '0, rx_desc = '0, rx_first_bd = '0, ir_req_desc = '0, ir_ans_desc = '0;
   logic [7:0] tx_attempts = '0, tx_retries = '0, rx_frame_ctrl = '0;
   logic [15:0] tx_data_len = '0, tx_first_buf_len = '0, rx_bytes_heard = '0, rx_bytes_copied = '0;
   logic rx_cmp_valid = 0, rx_crc_err = 0, rx_end_delimiter_error_flag_err = 0, rx_fifo_ovf = 0, rx_noise = 0;
   logic rx_no_buf = 0, rx_next_valid = 0, ir_valid = 0;
   logic [47:0] rx_dst_addr = '0, rx_src_addr = '0;
   logic rx_cmp_ready, rx_verdict_valid, rx_accept, ir_ready, next_link_valid, wfd, acc;
   logic [31:0] rdat;
   logic [16:0] sl;
   logic [1:0] vd, md;
   logic [15:0] fl, hd;
   logic [5:0] err, mk;
   logic [95:0] aw;
   int n, k, j, cyc = 0, error_cnt = 0, compares = 0;

   fdh_frame_descriptor_handler fdh_frame_descriptor_handler_i (.*);
   fdh_mem_model fdh_mem_model_i (.*);

   // ----------------------------------------
   // Clock, timeout and checking helpers
   // ----------------------------------------
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 40000) begin
         error_cnt++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Avalon access held until waitrequest is seen low
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= d;
      #1;
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   // Completion handshake, then wait for the engine to go idle
   task hs(input int w);
      sl = 'x;
      vd = 2'b00;
      if (w == 0) tx_cmp_valid <= 1'b1;
      else if (w == 1) rx_cmp_valid <= 1'b1;
      else ir_valid <= 1'b1;
      #1;
      while ((w == 0 ? tx_cmp_ready : w == 1 ? rx_cmp_ready : ir_ready) !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      tx_cmp_valid <= 1'b0;
      rx_cmp_valid <= 1'b0;
      ir_valid <= 1'b0;
      forever begin
         #1;
         if (tx_len_valid === 1'b1) sl = {tx_abort, tx_send_len};
         if (rx_verdict_valid === 1'b1) vd = {1'b1, rx_accept};
         if (ir_ready === 1'b1) break;
         @(posedge clk);
      end
      @(posedge clk);
   endtask
   // Expected stored receive length
   function automatic logic [15:0] rx_len(input logic [5:0] e, input logic [15:0] h, c,
                                          input logic sc);
      if (e[3] | e[2] | (h > 16'h2000)) return c;
      if (e[4] | e[0]) return h;
      return h + (sc ? 16'h0004 : 16'h0000);
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'h1985_6797));
      for (j = 0; j < 256; j++) fdh_mem_model_i.mem[j] = 16'h0000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      av(1'b0, 4'h0, '0);
      chk(rdat, 32'h0000_0000);
      av(1'b0, 4'h4, '0);
      chk(rdat, 32'h0000_0000);
      // Transmit confirmations with lengths around the host limit
      for (n = 0; n < 12; n++) begin
         next_link_valid = 1'($urandom);
         fl = 16'($urandom_range(32767));
         fdh_mem_model_i.mem[8'h20] = 16'h0000;
         fdh_mem_model_i.mem[8'h22] = {next_link_valid, 15'h0000};
         fdh_mem_model_i.mem[8'h28] = fl;
         lat <= 2'($urandom);
         tx_desc <= 32'h0000_0040;
         {tx_negative, tx_starvation, tx_no_answer} <= 3'($urandom);
         {tx_answer_on_retry, tx_unexpected, tx_retry_limit} <= 3'($urandom);
         tx_attempts <= 8'($urandom);
         tx_retries <= 8'($urandom);
         tx_data_len <= fl + 16'($urandom_range(2)) - 16'h0001;
         tx_first_buf_len <= fl + 16'($urandom_range(2)) - 16'h0001;
         hs(0);
         chk(sl, {tx_data_len > fl, (tx_first_buf_len < fl) ? tx_first_buf_len : fl});
         chk(fdh_mem_model_i.mem[8'h20], {1'b1, tx_negative | tx_no_answer, ~next_link_valid,
             tx_data_len > fl, 1'b0, tx_starvation, tx_no_answer | tx_answer_on_retry,
             tx_unexpected, tx_retry_limit ? tx_retries : tx_attempts});
      end
      // Received frames, one error kind at a time, random acceptance mask
      for (n = 0; n < 18; n++) begin
         k = $urandom_range(6);
         md = 2'($urandom);
         mk = 6'($urandom);
         av(1'b1, 4'h0, {30'h0, md});
         av(1'b1, 4'h4, {16'h0000, mk, 10'h000});
         err = (k < 6) ? (6'h20 >> k) : 6'h00;
         hd = (k == 4) ? 16'h2001 + 16'($urandom_range(99)) :
              (k == 6) ? 16'h2000 : 16'($urandom_range(8191));
         next_link_valid = 1'($urandom);
         wfd = next_link_valid & 1'($urandom);
         for (j = 8'h40; j < 8'h54; j++) fdh_mem_model_i.mem[j] = 16'h0000;
         fdh_mem_model_i.mem[8'h42] = {next_link_valid, wfd, 14'h0000};
         fdh_mem_model_i.mem[8'h4D] = {8'h00, 8'($urandom)};
         fl = fdh_mem_model_i.mem[8'h4D];
         lat <= 2'($urandom);
         rx_desc <= 32'h0000_0080;
         {rx_crc_err, rx_end_delimiter_error_flag_err, rx_fifo_ovf, rx_noise, rx_no_buf} <= {err[5:2], err[0]};
         rx_bytes_heard <= hd;
         rx_bytes_copied <= 16'($urandom_range(hd));
         rx_first_bd <= $urandom;
         rx_frame_ctrl <= 8'($urandom);
         rx_dst_addr <= 48'({$urandom, $urandom});
         rx_src_addr <= 48'({$urandom, $urandom});
         rx_next_valid <= 1'($urandom);
         hs(1);
         acc = (err == 6'h00) || ((err & mk) != 6'h00);
         chk(vd, {1'b1, acc});
         chk(fdh_mem_model_i.mem[8'h41], acc ? {err, 10'h000} : 16'h0000);
         if (acc) begin
            chk(fdh_mem_model_i.mem[8'h48], rx_len(err, hd, rx_bytes_copied, md[1]));
            chk(fdh_mem_model_i.mem[8'h46], rx_first_bd[31:16]);
            chk(fdh_mem_model_i.mem[8'h47], rx_first_bd[15:0]);
            chk(fdh_mem_model_i.mem[8'h4D], {rx_frame_ctrl, fl[7:0]});
            chk(fdh_mem_model_i.mem[8'h40], {rx_next_valid, 15'h0000});
            aw = md[0] ? {rx_src_addr, rx_dst_addr} :
                 {64'h0, rx_src_addr[15:0], rx_dst_addr[15:0]};
            for (j = 0; j < 6; j++) chk(fdh_mem_model_i.mem[8'h4E + j], aw[16 * j +: 16]);
         end
         av(1'b0, 4'h8, '0);
         chk(rdat[1:0], acc ? {wfd, ~next_link_valid} : 2'b00);
         av(1'b1, 4'h8, 32'h0000_0003);
      end
      // Answer descriptors linked to their requests
      for (n = 0; n < 4; n++) begin
         ir_req_desc <= 32'h0000_00C0;
         ir_ans_desc <= $urandom & 32'hFFFF_FFFE;
         hs(2);
         chk(fdh_mem_model_i.mem[8'h6B], ir_ans_desc[31:16]);
         chk(fdh_mem_model_i.mem[8'h6C], ir_ans_desc[15:0]);
      end
      wrap_up;
   end
endmodule

`default_nettype wire
